/* hdl/ipd_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef IPD_REGS_VH
`define IPD_REGS_VH
`define IPD_PWR_CTRL_OFFSET 4'h0
`define IPD_SER_CTRL_OFFSET 4'h4
`define IPD_STATUS_OFFSET   4'h8
`define IPD_CTRL_OFFSET     4'hc
`define IPD_BIT_IDLE        0
`define IPD_BIT_PWRDN       1
`define IPD_BIT_FLAG0       2
`define IPD_BIT_FLAG1       3
`define IPD_BIT_PWROFF      4
`define IPD_BIT_FRAME_SEL   6
`define IPD_BIT_BAUD_DBL    7
`define IPD_PWR_CTRL_RESET  8'h00
`define IPD_PWR_CTRL_WMASK  8'hdf
`define IPD_RST_OSC_PERIODS 64
`define IPD_OSC_PER_CLK     2
`define IPD_RST_CYCLES      (`IPD_RST_OSC_PERIODS / `IPD_OSC_PER_CLK)
`endif

/* hdl/ipd_serial_mux.v */
// steered serial control bit 7 store and baud doubling select
`timescale 1ns/1ps
module ipd_serial_mux
(
    // clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // access
    input  wire       wr_en,
    input  wire       wr_bit,
    input  wire       frame_err_select,
    input  wire       hw_fe_set,
    input  wire       baud_doubler,
    input  wire [1:0] serial_mode,
    input  wire       timer1_baud,
    // results
    output reg        rd_bit,
    output reg        framing_error_flag,
    output reg        serial_mode_bit_zero,
    output reg        baud_double
);
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            framing_error_flag   <= 1'b0;
            serial_mode_bit_zero <= 1'b0;
            rd_bit               <= 1'b0;
            baud_double          <= 1'b0;
        end
        else
        begin
            if (hw_fe_set)
                framing_error_flag <= 1'b1;
            else if (wr_en && frame_err_select) // RQ17
                framing_error_flag <= wr_bit;
            if (wr_en && !frame_err_select) // RQ17
                serial_mode_bit_zero <= wr_bit;
            rd_bit <= frame_err_select ? framing_error_flag
                                       : serial_mode_bit_zero;
            baud_double <= baud_doubler && timer1_baud
                           && (serial_mode != 2'h0); // RQ16
        end
    end
endmodule

/* hdl/ipd_power_ctrl.v */
// idle and power-down control with power control register on axi4-lite
//
// Summary of operation
// (RQ1) board holds reset through oscillator start plus 64
// (RQ2) board never pulls strobes low during reset
// (RQ3) board always resets at power-up
// (RQ4) reset forces port pins to reset levels
// (RQ5) idle gates cpu clock, peripherals keep running
// (RQ6) power-down stops every clock
// (RQ7) idle-setting instruction is the last executed
// (RQ8) idle freezes cpu state and port pins
// (RQ9) idle drives both strobes high
// (RQ10) counter array pauses or runs in idle
// (RQ11) enabled interrupt clears idle bit, ends idle
// (RQ12) reset pin clears idle bit directly
// (RQ13) two free general-purpose flag bits
// (RQ14) power-down wins when both bits written
// (RQ15) power-off flag set at power rise
// (RQ16) baud doubler doubles timer1 serial baud
// (RQ17) frame select steers serial bit 7
// (RQ18) any reset forces ports at once
// (RQ19) watchdog reset stretched to 64 periods
// (RQ20) power-down held until reset pin
`timescale 1ns/1ps
`include "ipd_regs.vh"
module ipd_power_ctrl
#(
    parameter RST_CYCLES = `IPD_RST_CYCLES
)
(
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // system events
    input  wire        reset_pin,
    input  wire        watchdog_expired,
    input  wire        power_rise,
    input  wire        enabled_irq,
    input  wire        cpu_instr_done,
    input  wire        hw_fe_set,
    input  wire [1:0]  serial_mode,
    input  wire        timer1_baud,
    // power state outputs
    output reg         cpu_clk_en,
    output reg         periph_clk_en,
    output reg         array_clk_en,
    output reg         osc_run,
    output reg         ports_hold,
    output reg         ports_force_reset,
    output reg         strobes_high,
    output reg         internal_reset,
    output reg         baud_double
);
    localparam ST_RUN   = 2'h0;
    localparam ST_IDLE  = 2'h1;
    localparam ST_PDOWN = 2'h2;
    reg  [1:0]  state;
    reg  [7:0]  power_control_reg;
    reg  [7:0]  serial_control_reg;
    reg         array_idle_pause;
    reg  [5:0]  wd_count;
    reg  [3:0]  wr_addr;
    reg  [31:0] wr_data;
    reg  [3:0]  wr_strb;
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  next_power_control;
    wire [31:0] merged_word;
    wire        frame_err_q;
    wire        mode_bit0;
    wire        sc7_rd;
    wire        baud_dbl;
    wire        do_write;
    wire        pwr_ctrl_wr;
    wire        ser_ctrl_wr;
    wire        wd_active;
    wire        any_reset;

    function [31:0] ipd_merge;
        input [31:0] old;
        input [31:0] din;
        input [3:0]  strb;
        integer i;
        begin
            ipd_merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    ipd_merge[i*8 +: 8] = din[i*8 +: 8];
        end
    endfunction

    assign do_write    = aw_held && w_held && !s_axi_bvalid;
    assign pwr_ctrl_wr = do_write && (wr_addr == `IPD_PWR_CTRL_OFFSET)
                         && wr_strb[0];
    assign ser_ctrl_wr = do_write && (wr_addr == `IPD_SER_CTRL_OFFSET)
                         && wr_strb[0];
    assign merged_word = ipd_merge({24'h0, power_control_reg},
                                   wr_data, wr_strb);
    assign wd_active = (wd_count != 6'h00);
    assign any_reset = reset_pin || watchdog_expired || wd_active;

    ipd_serial_mux u_serial
    (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .wr_en                (ser_ctrl_wr),
        .wr_bit               (wr_data[7]),
        .frame_err_select     (power_control_reg[`IPD_BIT_FRAME_SEL]),
        .hw_fe_set            (hw_fe_set),
        .baud_doubler         (power_control_reg[`IPD_BIT_BAUD_DBL]),
        .serial_mode          (serial_mode),
        .timer1_baud          (timer1_baud),
        .rd_bit               (sc7_rd),
        .framing_error_flag   (frame_err_q),
        .serial_mode_bit_zero (mode_bit0),
        .baud_double          (baud_dbl)
    );

    // next power control value: software write, then hardware effects
    always @*
    begin
        next_power_control = power_control_reg;
        if (pwr_ctrl_wr)
            next_power_control = merged_word[7:0]
                                 & `IPD_PWR_CTRL_WMASK; // RQ13
        if (next_power_control[`IPD_BIT_PWRDN])
            next_power_control[`IPD_BIT_IDLE] = 1'b0; // RQ14
        if (enabled_irq && state == ST_IDLE)
            next_power_control[`IPD_BIT_IDLE] = 1'b0; // RQ11
        if (power_rise)
            next_power_control[`IPD_BIT_PWROFF] = 1'b1; // RQ15
        if (reset_pin)
            next_power_control[`IPD_BIT_IDLE] = 1'b0; // RQ12
        if (reset_pin && state == ST_PDOWN)
            next_power_control[`IPD_BIT_PWRDN] = 1'b0; // RQ20
    end

    // axi write channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            wr_addr       <= 4'h0;
            wr_data       <= 32'h0;
            wr_strb       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr == `IPD_PWR_CTRL_OFFSET ||
                                 wr_addr == `IPD_SER_CTRL_OFFSET ||
                                 wr_addr == `IPD_CTRL_OFFSET)
                                ? 2'h0 : 2'h2;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // registers and power state
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            power_control_reg  <= `IPD_PWR_CTRL_RESET;
            serial_control_reg <= 8'h00;
            array_idle_pause   <= 1'b0;
            state              <= ST_RUN;
        end
        else
        begin
            power_control_reg <= next_power_control;
            if (ser_ctrl_wr)
                serial_control_reg <= wr_data[7:0];
            if (do_write && wr_addr == `IPD_CTRL_OFFSET && wr_strb[0])
                array_idle_pause <= wr_data[0]; // RQ10
            case (state)
                ST_RUN:
                    if (any_reset)
                        state <= ST_RUN;
                    else if (next_power_control[`IPD_BIT_PWRDN]
                             && cpu_instr_done)
                        state <= ST_PDOWN; // RQ14
                    else if (next_power_control[`IPD_BIT_IDLE]
                             && cpu_instr_done)
                        state <= ST_IDLE; // RQ7
                ST_IDLE:
                    if (!next_power_control[`IPD_BIT_IDLE])
                        state <= ST_RUN; // RQ11
                ST_PDOWN:
                    if (reset_pin)
                    begin
                        state <= ST_RUN; // RQ20
                    end
                default:
                    state <= ST_RUN;
            endcase
        end
    end

    // watchdog reset stretcher
    always @(posedge aclk)
    begin
        if (!aresetn)
            wd_count <= 6'h00;
        else if (watchdog_expired)
            wd_count <= RST_CYCLES[5:0]; // RQ19
        else if (wd_active)
            wd_count <= wd_count - 6'h01;
    end

    // registered power outputs
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_clk_en        <= 1'b0;
            periph_clk_en     <= 1'b0;
            array_clk_en      <= 1'b0;
            osc_run           <= 1'b1;
            ports_hold        <= 1'b0;
            ports_force_reset <= 1'b1;
            strobes_high      <= 1'b1;
            internal_reset    <= 1'b1;
            baud_double       <= 1'b0;
        end
        else
        begin
            osc_run       <= (state != ST_PDOWN); // RQ6
            periph_clk_en <= (state != ST_PDOWN); // RQ5
            cpu_clk_en    <= (state == ST_RUN) && !any_reset; // RQ5
            array_clk_en  <= (state == ST_RUN) ||
                             (state == ST_IDLE && !array_idle_pause); // RQ10
            ports_hold    <= (state == ST_IDLE); // RQ8
            ports_force_reset <= any_reset; // RQ4 RQ18
            strobes_high  <= (state == ST_IDLE) || any_reset; // RQ9
            internal_reset <= any_reset; // RQ19
            baud_double   <= baud_dbl; // RQ16
        end
    end

    // axi read channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'h0;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `IPD_PWR_CTRL_OFFSET:
                        s_axi_rdata <= {24'h0, power_control_reg};
                    `IPD_SER_CTRL_OFFSET:
                        s_axi_rdata <= {24'h0, sc7_rd,
                                        serial_control_reg[6:0]}; // RQ17
                    `IPD_STATUS_OFFSET:
                        s_axi_rdata <= {28'h0, frame_err_q, mode_bit0,
                                        state};
                    `IPD_CTRL_OFFSET:
                        s_axi_rdata <= {31'h0, array_idle_pause};
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* test/ipd_power_ctrl_asserts.sv */
// checker for the power state outputs
`timescale 1ns/1ps
module ipd_power_ctrl_asserts
#(
    parameter RST_CYCLES = 32
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // events
    input wire reset_pin,
    input wire watchdog_expired,
    input wire enabled_irq,
    // power state
    input wire cpu_clk_en,
    input wire periph_clk_en,
    input wire array_clk_en,
    input wire osc_run,
    input wire ports_hold,
    input wire ports_force_reset,
    input wire strobes_high,
    input wire internal_reset
);
    logic [7:0] run_len;
    logic       wd_seen;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // length of each internal reset run
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            run_len <= 8'h00;
            wd_seen <= 1'b0;
        end
        else
        begin
            run_len <= internal_reset ? run_len + 8'h01 : 8'h00;
            if (watchdog_expired)
                wd_seen <= 1'b1;
            else if (!internal_reset && run_len != 8'h00)
                wd_seen <= 1'b0;
        end
    end
    a_idle_gate:
        assert property (ports_hold && osc_run |-> !cpu_clk_en
            && periph_clk_en && strobes_high)
        else $error("idle clocks or strobes wrong");
    a_pwrdn_stops:
        assert property (!osc_run |-> !cpu_clk_en && !periph_clk_en
            && !array_clk_en)
        else $error("clock running in power-down");
    a_irq_wakes:
        assert property (ports_hold && osc_run && enabled_irq
            && !reset_pin |-> ##[1:3] cpu_clk_en)
        else $error("interrupt did not end idle");
    a_pin_wakes:
        assert property (ports_hold && reset_pin |-> ##[1:3] !ports_hold)
        else $error("reset pin did not end idle");
    a_pwrdn_holds:
        assert property (!osc_run && !reset_pin |=> !osc_run)
        else $error("power-down left without reset pin");
    a_pin_forces:
        assert property (reset_pin |-> ##[1:2] ports_force_reset)
        else $error("ports not forced by reset pin");
    a_wd_forces:
        assert property ($rose(watchdog_expired) |-> ##[1:2]
            (ports_force_reset && internal_reset))
        else $error("ports not forced by watchdog");
    a_wd_stretch:
        assert property (wd_seen && $fell(internal_reset) |->
            run_len >= RST_CYCLES - 1 && run_len <= RST_CYCLES + 1)
        else $error("watchdog reset stretch wrong");
endmodule
bind ipd_power_ctrl ipd_power_ctrl_asserts
    #(.RST_CYCLES(RST_CYCLES)) i_chk (.*);

/* test/ipd_board_model.sv */
// board reset network: holds reset pin at power-up and on request
`timescale 1ns/1ps
module ipd_board_model
#(
    parameter HOLD = 40
)
(
    // clock
    input  wire aclk,
    // request and pin
    input  wire kick,
    output wire reset_pin
);
    // strobes are not connected here, so never pulled low
    logic [7:0] cnt = 8'(HOLD);
    assign reset_pin = (cnt != 8'h00);
    always @(posedge aclk)
    begin
        if (kick)
            cnt <= 8'(HOLD);
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
    end
endmodule

/* test/tb_top.sv */
// self-checking bench for idle and power-down control
`timescale 1ns/1ps
module tb_top;
    logic aclk = 0, aresetn = 0, kick = 0;
    logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, watchdog_expired = 0;
    logic power_rise = 0, enabled_irq = 0, cpu_instr_done = 1;
    logic hw_fe_set = 0, timer1_baud = 0;
    logic [1:0] serial_mode = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, reset_pin, cpu_clk_en, periph_clk_en, array_clk_en;
    wire osc_run, ports_hold, ports_force_reset, strobes_high;
    wire internal_reset, baud_double;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    logic [33:0] q[$];
    logic [7:0] d;
    int n_errors = 0, checks_done = 0, cyc = 0;
    ipd_power_ctrl #(.RST_CYCLES(4)) i_dut (.*);
    ipd_board_model #(.HOLD(40)) i_board (.aclk(aclk), .kick(kick),
        .reset_pin(reset_pin));
    always #12.5 aclk = ~aclk;
    task close_out;
    begin
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    task chk(input string nm, input logic [33:0] seen, exp);
    begin
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
    begin
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    end
    endtask
    task rd(input logic [3:0] a, input logic [33:0] e);
    begin
        q.push_back(e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
    end
    endtask
    // one request pulse to the board, then wait out the pin
    task pin_rst;
    begin
        @(posedge aclk);
        kick <= 1;
        @(posedge aclk);
        kick <= 0;
        do @(posedge aclk); while (reset_pin);
        repeat (8) @(posedge aclk);
    end
    endtask
    // read answers against the oldest note
    always @(posedge aclk)
        if (s_axi_rvalid && s_axi_rready)
            chk("read", {s_axi_rresp, s_axi_rdata}, q.pop_front());
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            close_out;
        end
    end
    initial
    begin
        void'($urandom(32'h0e004485));
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        do @(posedge aclk); while (reset_pin);
        repeat (8) @(posedge aclk);
        rd(4'h0, 34'h0);
        @(posedge aclk) power_rise <= 1;
        @(posedge aclk) power_rise <= 0;
        rd(4'h0, 34'h10);
        repeat (4)
        begin
            d = 8'($urandom) & 8'hdc;
            wr(4'h0, d);
            rd(4'h0, {26'h0, d});
        end
        wr(4'h0, 8'h00);
        rd(4'h2, {2'b10, 32'h0});
        wr(4'hc, 8'h01);
        wr(4'h0, 8'h05);
        rd(4'h8, 34'h1);
        rd(4'h0, 34'h5);
        chk("array clock", {33'h0, array_clk_en}, 34'h0);
        chk("cpu clock", {33'h0, cpu_clk_en}, 34'h0);
        chk("periph clock", {33'h0, periph_clk_en}, 34'h1);
        chk("port hold", {33'h0, ports_hold}, 34'h1);
        chk("strobes", {33'h0, strobes_high}, 34'h1);
        @(posedge aclk) enabled_irq <= 1;
        repeat (3) @(posedge aclk);
        enabled_irq <= 0;
        rd(4'h0, 34'h4);
        rd(4'h8, 34'h0);
        chk("cpu clock", {33'h0, cpu_clk_en}, 34'h1);
        wr(4'hc, 8'h00);
        wr(4'h0, 8'h01);
        repeat (3) @(posedge aclk);
        chk("port hold", {33'h0, ports_hold}, 34'h1);
        chk("array clock", {33'h0, array_clk_en}, 34'h1);
        pin_rst;
        rd(4'h8, 34'h0);
        wr(4'h0, 8'h03);
        rd(4'h0, 34'h2);
        repeat (20) @(posedge aclk);
        rd(4'h8, 34'h2);
        chk("osc", {33'h0, osc_run}, 34'h0);
        chk("cpu clock", {33'h0, cpu_clk_en}, 34'h0);
        pin_rst;
        rd(4'h8, 34'h0);
        chk("osc", {33'h0, osc_run}, 34'h1);
        @(posedge aclk) watchdog_expired <= 1;
        @(posedge aclk) watchdog_expired <= 0;
        @(posedge aclk);
        chk("int reset", {33'h0, internal_reset}, 34'h1);
        chk("port force", {33'h0, ports_force_reset}, 34'h1);
        repeat (16) @(posedge aclk);
        chk("int reset", {33'h0, internal_reset}, 34'h0);
        wr(4'h0, 8'h40);
        wr(4'h4, 8'h80);
        rd(4'h8, 34'h8);
        rd(4'h4, 34'h80);
        wr(4'h0, 8'h00);
        rd(4'h4, 34'h0);
        wr(4'h4, 8'h80);
        rd(4'h8, 34'hc);
        wr(4'h0, 8'h80);
        timer1_baud <= 1;
        for (int m = 0; m < 4; m++)
        begin
            serial_mode <= 2'(m);
            repeat (4) @(posedge aclk);
            chk("baud", {33'h0, baud_double}, {33'h0, m != 0});
        end
        timer1_baud <= 0;
        repeat (4) @(posedge aclk);
        chk("baud", {33'h0, baud_double}, 34'h0);
        close_out;
    end
endmodule
